// file: design/rsg_regs.svh
// Constants for the reset and sleep gating block
`ifndef RSG_REGS_SVH
`define RSG_REGS_SVH

`define RSG_ADDR_W           4
`define RSG_ADDR_STATUS      4'h0
`define RSG_ADDR_CTRL        4'h1
`define RSG_ADDR_SLEEP       4'h2
`define RSG_ADDR_ID          4'h3
`define RSG_FLAG_POR         0
`define RSG_FLAG_PIN         1
`define RSG_FLAG_BOD         2
`define RSG_FLAG_WDT         3
`define RSG_FLAG_SCAN        4
`define RSG_CTRL_SCAN_DIS    7
`define RSG_CTRL_ADC_EN      0
`define RSG_CTRL_ACMP_DIS    1
`define RSG_CTRL_ACMP_BG     2
`define RSG_CTRL_WDT_EN      3
`define RSG_CTRL_RESET       8'h00
`define RSG_SLEEP_RESET      3'h0
// Arbitrary value; names no maker or part
`define RSG_ID_VALUE         8'h5a
`define RSG_CLK_MHZ          100
`define RSG_DLY_SHORT_US     4
`define RSG_DLY_LONG_US      65
`define RSG_DLY_SHORT_CYC    (`RSG_DLY_SHORT_US * `RSG_CLK_MHZ)
`define RSG_DLY_LONG_CYC     (`RSG_DLY_LONG_US * `RSG_CLK_MHZ)
`define RSG_CNT_W            13

`endif

// file: design/rsg_pkg.sv
// Types for the reset and sleep gating block
package rsg_pkg;
  typedef enum logic [2:0]
  {
    RSG_SM_IDLE     = 3'h0,
    RSG_SM_NOISE    = 3'h1,
    RSG_SM_PDOWN    = 3'h2,
    RSG_SM_PSAVE    = 3'h3,
    RSG_SM_RSV4     = 3'h4,
    RSG_SM_RSV5     = 3'h5,
    RSG_SM_STANDBY  = 3'h6,
    RSG_SM_EXTSTBY  = 3'h7
  } rsg_sleep_e;

  typedef enum logic [1:0]
  {
    RSG_ST_HOLD  = 2'b00,
    RSG_ST_DELAY = 2'b01,
    RSG_ST_RUN   = 2'b11
  } rsg_state_e;

  typedef logic [7:0] rsg_byte_t;
endpackage

// file: design/rsg_delay.sv
// Reset stretch counter started when all reset sources have released
`timescale 1ns/1ps
`default_nettype none
`include "rsg_regs.svh"
module rsg_delay
  import rsg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  req,
  input  wire logic                  long_sel,
  output logic                       rst_out
);
  localparam logic [`RSG_CNT_W-1:0] SHORT_C = `RSG_CNT_W'(`RSG_DLY_SHORT_CYC - 1);
  localparam logic [`RSG_CNT_W-1:0] LONG_C  = `RSG_CNT_W'(`RSG_DLY_LONG_CYC - 1);

  rsg_state_e              st_q;
  rsg_state_e              st_d;
  logic [`RSG_CNT_W-1:0]   cnt_q;
  logic [`RSG_CNT_W-1:0]   cnt_d;
  wire  [`RSG_CNT_W-1:0]   limit = long_sel ? LONG_C : SHORT_C;

  // Request acts without the clock; count starts only after every source drops
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      RSG_ST_HOLD:
      begin
        st_d  = RSG_ST_DELAY;
        cnt_d = '0;
      end
      RSG_ST_DELAY:
      begin
        if (cnt_q == limit)
          st_d = RSG_ST_RUN;
        else
          cnt_d = cnt_q + `RSG_CNT_W'(1);
      end
      RSG_ST_RUN:
      begin
        st_d = RSG_ST_RUN;
      end
      default:
      begin
        st_d = RSG_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or posedge req)
  begin
    if (req)
    begin
      st_q  <= RSG_ST_HOLD;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign rst_out = req | (st_q != RSG_ST_RUN);

  a_delay_length: assert property (@(posedge clk) disable iff (req)
    $rose(st_q == RSG_ST_DELAY) |-> (st_q == RSG_ST_DELAY)[*8])
    else $error("reset stretch ended too early");
endmodule
`default_nettype wire

// file: design/rsg_top.sv
// Reset merging, reset flags and sleep gating of analog and clock modules
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rsg_regs.svh"
module rsg_top
  import rsg_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   SUPPLY_LOW,
  input  wire logic                   RESET_PIN_N,
  input  wire logic                   WDT_EXPIRE,
  input  wire logic                   BROWNOUT_LOW,
  input  wire logic                   SCAN_RESET_REG,
  input  wire logic                   BROWNOUT_ENABLE_FUSE,
  input  wire logic                   DEBUG_ENABLE_FUSE,
  input  wire logic                   SCAN_PORT_ENABLE_FUSE,
  input  wire logic                   CLOCK_SELECT_LONG,
  input  wire logic                   SLEEP_ACTIVE,
  input  wire logic                   TAP_SHIFTING,
  input  wire logic                   TAP_TDO,
  input  wire logic [`RSG_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [7:0]             RDATA,
  output logic                        INT_RESET,
  output logic                        PORT_RESET,
  output logic                        ADC_ENABLE,
  output logic                        ADC_EXTENDED,
  output logic                        ACMP_ENABLE,
  output logic                        VREF_ENABLE,
  output logic                        BOD_ENABLE,
  output logic                        WDT_RUN,
  output logic                        INPUT_BUF_EN,
  output logic                        MAIN_CLK_EN,
  output logic                        IO_CLK_EN,
  output logic                        CONV_CLK_EN,
  output logic                        SCAN_ENABLE,
  output logic                        TDO_O,
  output logic                        TDO_OE
);
  import rsg_pkg::*;

  // Watchdog reset is a single cycle pulse, not the level
  // Registered: the reset it causes clears the enable that gates it
  logic wdt_prev_q;
  logic wdt_pulse_q;
  wire  wdt_edge  = WDT_EXPIRE & ~wdt_prev_q & WDT_RUN;
  wire  wdt_pulse = wdt_pulse_q;
  wire  src_por  = SUPPLY_LOW;
  wire  src_pin  = ~RESET_PIN_N;
  wire  src_bod  = BROWNOUT_LOW & BROWNOUT_ENABLE_FUSE;
  wire  src_scan = SCAN_RESET_REG;
  wire  reset_req = src_por | src_pin | src_bod | wdt_pulse | src_scan | RST;

  // Ports clear straight from the request, with no clock in the path
  assign PORT_RESET = reset_req;

  rsg_delay u_delay
  (
    .clk      (CLK),
    .req      (reset_req),
    .long_sel (CLOCK_SELECT_LONG),
    .rst_out  (INT_RESET)
  );

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wdt_prev_q  <= 1'b0;
      wdt_pulse_q <= 1'b0;
    end
    else
    begin
      wdt_prev_q  <= WDT_EXPIRE;
      wdt_pulse_q <= wdt_edge;
    end
  end

  // Flags survive internal reset; only power-on, RST and zero bits written to status clear them
  logic [4:0] flags_q;
  logic [4:0] flags_d;
  wire        wr_status = WR & (ADDR == `RSG_ADDR_STATUS);
  wire  [4:0] src_vec;
  assign src_vec[`RSG_FLAG_POR]  = src_por;
  assign src_vec[`RSG_FLAG_PIN]  = src_pin;
  assign src_vec[`RSG_FLAG_BOD]  = src_bod;
  assign src_vec[`RSG_FLAG_WDT]  = wdt_pulse;
  assign src_vec[`RSG_FLAG_SCAN] = src_scan;

  // Set beats a same-cycle zero write
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_flag
      if (g == `RSG_FLAG_POR)
      begin : g_por
        assign flags_d[g] = src_vec[g] | (flags_q[g] & ~(wr_status & ~WDATA[g]));
      end
      else
      begin : g_oth
        assign flags_d[g] = ~src_por & (src_vec[g] | (flags_q[g] & ~(wr_status & ~WDATA[g])));
      end
    end
  endgenerate

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      flags_q <= 5'h01;
    else
      flags_q <= flags_d;
  end

  // Control and sleep registers return to initial values during reset
  logic [7:0] ctrl_q;
  logic [2:0] sleep_q;
  wire        wr_ctrl  = WR & (ADDR == `RSG_ADDR_CTRL);
  wire        wr_sleep = WR & (ADDR == `RSG_ADDR_SLEEP);

  always_ff @(posedge CLK or posedge INT_RESET)
  begin
    if (INT_RESET)
    begin
      ctrl_q  <= `RSG_CTRL_RESET;
      sleep_q <= `RSG_SLEEP_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= WDATA;
      if (wr_sleep)
        sleep_q <= WDATA[2:0];
    end
  end

  wire        adc_on    = ctrl_q[`RSG_CTRL_ADC_EN];
  wire        acmp_off  = ctrl_q[`RSG_CTRL_ACMP_DIS];
  wire        acmp_bg   = ctrl_q[`RSG_CTRL_ACMP_BG];
  rsg_sleep_e mode;
  assign mode = rsg_sleep_e'(sleep_q);

  function automatic logic io_stops(input rsg_sleep_e m);
    io_stops = (m != RSG_SM_IDLE);
  endfunction

  function automatic logic conv_stops(input rsg_sleep_e m);
    conv_stops = (m != RSG_SM_IDLE) && (m != RSG_SM_NOISE);
  endfunction

  // Clock domains follow the sleep select encoding
  assign IO_CLK_EN   = ~(SLEEP_ACTIVE & io_stops(mode));
  assign CONV_CLK_EN = ~(SLEEP_ACTIVE & conv_stops(mode));

  // Converter is never gated by sleep
  assign ADC_ENABLE = adc_on;

  // Comparator gated in every mode that stops the converter clock
  // Its reference request still follows only the software disable and bandgap select bits, not sleep
  assign ACMP_ENABLE = ~acmp_off & ~(SLEEP_ACTIVE & conv_stops(mode));

  assign BOD_ENABLE = BROWNOUT_ENABLE_FUSE;
  assign WDT_RUN    = ctrl_q[`RSG_CTRL_WDT_EN];

  // Reference held in sleep when an enabled comparator selects it
  assign VREF_ENABLE = BROWNOUT_ENABLE_FUSE | adc_on | (acmp_bg & ~acmp_off);

  // Wake pins keep their buffers on elsewhere; this gate covers the rest
  assign INPUT_BUF_EN = IO_CLK_EN | CONV_CLK_EN;

  // Debug needs the main oscillator in the two deepest modes
  wire deep_stop = SLEEP_ACTIVE & ((mode == RSG_SM_PDOWN) | (mode == RSG_SM_PSAVE));
  assign MAIN_CLK_EN = ~deep_stop | DEBUG_ENABLE_FUSE;

  assign SCAN_ENABLE = SCAN_PORT_ENABLE_FUSE & ~ctrl_q[`RSG_CTRL_SCAN_DIS];

  // Pin floats when idle; the far side pulls it up
  assign TDO_OE = SCAN_ENABLE & TAP_SHIFTING;
  assign TDO_O  = TAP_TDO;

  // Extended conversion after an off-to-on transition of the converter
  logic adc_prev_q;
  logic ext_q;
  always_ff @(posedge CLK or posedge INT_RESET)
  begin
    if (INT_RESET)
    begin
      adc_prev_q <= 1'b0;
      ext_q      <= 1'b1;
    end
    else
    begin
      adc_prev_q <= adc_on;
      ext_q      <= (adc_on & ~adc_prev_q) | (ext_q & adc_on);
    end
  end
  assign ADC_EXTENDED = ext_q;

  // Read data in the cycle after the strobe
  wire [7:0] rd_mux = (ADDR == `RSG_ADDR_STATUS) ? {3'h0, flags_q} :
                      (ADDR == `RSG_ADDR_CTRL)   ? ctrl_q :
                      (ADDR == `RSG_ADDR_SLEEP)  ? {5'h00, sleep_q} :
                      (ADDR == `RSG_ADDR_ID)     ? `RSG_ID_VALUE : 8'h00;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rd_mux;
    else
      RDATA <= 8'h00;
  end

  a_wdt_pulse_one: assert property (@(posedge CLK) disable iff (RST)
    wdt_pulse |=> !wdt_pulse)
    else $error("watchdog pulse longer than one cycle");
  a_ports_async: assert property (@(posedge CLK) disable iff (RST)
    src_pin |-> PORT_RESET && INT_RESET)
    else $error("pin reset not seen at ports");
  a_por_clears: assert property (@(posedge CLK) disable iff (RST)
    src_por |=> flags_q[`RSG_FLAG_POR] && flags_q[4:1] == 4'h0)
    else $error("power-on did not clear other flags");
  a_flag_set_wins: assert property (@(posedge CLK) disable iff (RST)
    (src_pin && !src_por && wr_status) |=> flags_q[`RSG_FLAG_PIN])
    else $error("flag set lost to clear");
  a_dbg_clock: assert property (@(posedge CLK) disable iff (RST)
    DEBUG_ENABLE_FUSE |-> MAIN_CLK_EN)
    else $error("main clock stopped with debug enabled");
  a_tdo_float: assert property (@(posedge CLK) disable iff (RST)
    !TAP_SHIFTING |-> !TDO_OE)
    else $error("tdo driven while not shifting");
  a_scan_disable: assert property (@(posedge CLK) disable iff (RST)
    (wr_ctrl && WDATA[`RSG_CTRL_SCAN_DIS] && !INT_RESET) |=> !SCAN_ENABLE)
    else $error("scan port not disabled");
  a_adc_extend: assert property (@(posedge CLK) disable iff (INT_RESET)
    $rose(adc_on) |=> ADC_EXTENDED)
    else $error("extended conversion not flagged");
  a_acmp_gate: assert property (@(posedge CLK) disable iff (RST)
    (SLEEP_ACTIVE && mode == RSG_SM_PDOWN && !acmp_bg) |-> !ACMP_ENABLE)
    else $error("comparator active in power-down");

  c_wdt_reset:  cover property (@(posedge CLK) disable iff (RST) wdt_pulse);
  c_pin_reset:  cover property (@(posedge CLK) disable iff (RST) $fell(src_pin));
  c_deep_sleep: cover property (@(posedge CLK) disable iff (RST) deep_stop && !MAIN_CLK_EN);
  c_flag_clear: cover property (@(posedge CLK) disable iff (RST) wr_status && WDATA == 8'h00);
endmodule
`default_nettype wire

// file: test/rsg_far_side.sv
// Model of the supply detectors, external reset pin and scan port
`timescale 1ns/1ps
`default_nettype none
module rsg_far_side #(
  parameter int PIN_MIN = 150
)(
  input  wire logic       clk,
  input  wire logic [3:0] want,
  output logic            supply_low,
  output logic            reset_pin_n,
  output logic            brownout_low,
  output logic            scan_reset_reg,
  output logic            tap_tdo
);
  int pin_cnt;
  initial
  begin
    supply_low = 1'b1;
    reset_pin_n = 1'b1;
    brownout_low = 1'b0;
    scan_reset_reg = 1'b0;
    tap_tdo = 1'b0;
    pin_cnt = 0;
  end
  always @(posedge clk)
  begin
    supply_low <= want[0];
    brownout_low <= want[2];
    scan_reset_reg <= want[3];
    // Pin held low for at least the minimum pulse, even if asked shorter
    pin_cnt <= want[1] ? PIN_MIN : (pin_cnt > 0 ? pin_cnt - 1 : 0);
    reset_pin_n <= !(want[1] || pin_cnt > 1);
    // Toggles every cycle so stale data never looks valid
    tap_tdo <= ~tap_tdo;
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the reset and sleep gating block
`timescale 1ns/1ps
`default_nettype none
`include "rsg_regs.svh"
module tb;
  import rsg_pkg::*;
  logic       CLK, RST, WDT_EXPIRE, BROWNOUT_ENABLE_FUSE, DEBUG_ENABLE_FUSE, SCAN_PORT_ENABLE_FUSE;
  logic       CLOCK_SELECT_LONG, SLEEP_ACTIVE, TAP_SHIFTING, WR, RD;
  logic [3:0] ADDR, want;
  logic [7:0] WDATA, ctl, rv;
  logic [2:0] md;
  wire logic [7:0] RDATA;
  wire logic  SUPPLY_LOW, RESET_PIN_N, BROWNOUT_LOW, SCAN_RESET_REG, TAP_TDO, INT_RESET, PORT_RESET;
  wire logic  ADC_ENABLE, ADC_EXTENDED, ACMP_ENABLE, VREF_ENABLE, BOD_ENABLE, WDT_RUN, INPUT_BUF_EN;
  wire logic  MAIN_CLK_EN, IO_CLK_EN, CONV_CLK_EN, SCAN_ENABLE, TDO_O, TDO_OE;
  int         n_fail, checked, n, d, s, k;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  rsg_far_side u_rsg_far_side(.clk(CLK), .want(want), .supply_low(SUPPLY_LOW), .reset_pin_n(RESET_PIN_N),
    .brownout_low(BROWNOUT_LOW), .scan_reset_reg(SCAN_RESET_REG), .tap_tdo(TAP_TDO));
  rsg_top u_rsg_top(.CLK(CLK), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW), .RESET_PIN_N(RESET_PIN_N),
    .WDT_EXPIRE(WDT_EXPIRE), .BROWNOUT_LOW(BROWNOUT_LOW), .SCAN_RESET_REG(SCAN_RESET_REG),
    .BROWNOUT_ENABLE_FUSE(BROWNOUT_ENABLE_FUSE), .DEBUG_ENABLE_FUSE(DEBUG_ENABLE_FUSE),
    .SCAN_PORT_ENABLE_FUSE(SCAN_PORT_ENABLE_FUSE), .CLOCK_SELECT_LONG(CLOCK_SELECT_LONG),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .TAP_SHIFTING(TAP_SHIFTING), .TAP_TDO(TAP_TDO), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .INT_RESET(INT_RESET), .PORT_RESET(PORT_RESET), .ADC_ENABLE(ADC_ENABLE),
    .ADC_EXTENDED(ADC_EXTENDED), .ACMP_ENABLE(ACMP_ENABLE), .VREF_ENABLE(VREF_ENABLE), .BOD_ENABLE(BOD_ENABLE),
    .WDT_RUN(WDT_RUN), .INPUT_BUF_EN(INPUT_BUF_EN), .MAIN_CLK_EN(MAIN_CLK_EN), .IO_CLK_EN(IO_CLK_EN),
    .CONV_CLK_EN(CONV_CLK_EN), .SCAN_ENABLE(SCAN_ENABLE), .TDO_O(TDO_O), .TDO_OE(TDO_OE));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask

  // Bounded wait for PORT_RESET (sel 0) or INT_RESET (sel 1) to reach lvl
  task automatic wait_sig(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (((sel == 0) ? PORT_RESET : INT_RESET) !== lvl)
    begin
      @(posedge CLK);
      #1 cnt++;
      if (cnt > 8000)
      begin
        n_fail++;
        conclude();
      end
    end
  endtask

  initial
  begin
    {RST, WDT_EXPIRE, WR, RD, SLEEP_ACTIVE, TAP_SHIFTING, CLOCK_SELECT_LONG, DEBUG_ENABLE_FUSE} = '1;
    {WDT_EXPIRE, WR, RD, SLEEP_ACTIVE, TAP_SHIFTING, CLOCK_SELECT_LONG, DEBUG_ENABLE_FUSE} = '0;
    {BROWNOUT_ENABLE_FUSE, SCAN_PORT_ENABLE_FUSE} = 2'b01;
    ADDR = 4'h0;
    WDATA = 8'h00;
    want = 4'h0;
    n_fail = 0;
    checked = 0;
    void'($urandom(4987));
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    wait_sig(1, 1'b0, n);
    chk(ADC_ENABLE, 1'b0);
    rd(`RSG_ADDR_ID, rv);
    chk(rv, `RSG_ID_VALUE);
    rd(4'hf, rv);
    chk(rv, 8'h00);
    rd(`RSG_ADDR_STATUS, rv);
    chk(rv, 8'h01);
    wr(`RSG_ADDR_CTRL, 8'h00);
    wr(`RSG_ADDR_CTRL, 8'h01);
    @(posedge CLK);
    #1 chk(ADC_EXTENDED, 1'b1);
    for (k = 0; k < 24; k++)
    begin
      md = modes[k % 6];
      ctl = 8'($urandom) & 8'h8f;
      wr(`RSG_ADDR_CTRL, ctl);
      wr(`RSG_ADDR_SLEEP, {5'h00, md});
      {SLEEP_ACTIVE, TAP_SHIFTING, DEBUG_ENABLE_FUSE, BROWNOUT_ENABLE_FUSE, SCAN_PORT_ENABLE_FUSE} <= 5'($urandom);
      repeat (2) @(posedge CLK);
      #1 chk(ADC_ENABLE, ctl[0]);
      chk(ACMP_ENABLE, !ctl[1] && !(SLEEP_ACTIVE && md > 3'h1));
      chk(VREF_ENABLE, BROWNOUT_ENABLE_FUSE | ctl[0] | (ctl[2] & !ctl[1]));
      chk(BOD_ENABLE, BROWNOUT_ENABLE_FUSE);
      chk(WDT_RUN, ctl[3]);
      chk(INPUT_BUF_EN, !(SLEEP_ACTIVE && md > 3'h1));
      chk(MAIN_CLK_EN, !(SLEEP_ACTIVE && md inside {3'h2, 3'h3}) || DEBUG_ENABLE_FUSE);
      chk({IO_CLK_EN, CONV_CLK_EN}, {!(SLEEP_ACTIVE && md != 3'h0), !(SLEEP_ACTIVE && md > 3'h1)});
      chk(SCAN_ENABLE, SCAN_PORT_ENABLE_FUSE & !ctl[7]);
      chk(TDO_OE, SCAN_PORT_ENABLE_FUSE & !ctl[7] & TAP_SHIFTING);
      if (TDO_OE === 1'b1)
        chk(TDO_O, TAP_TDO);
    end
    SLEEP_ACTIVE <= 1'b0;
    BROWNOUT_ENABLE_FUSE <= 1'b1;
    for (s = 0; s < 5; s++)
    begin
      CLOCK_SELECT_LONG <= (s == 1);
      wr(`RSG_ADDR_STATUS, 8'h00);
      if (s == 3)
      begin
        wr(`RSG_ADDR_CTRL, 8'h08);
        WDT_EXPIRE <= 1'b1;
      end
      else
        want <= 4'(1 << (s > 3 ? 3 : s));
      wait_sig(0, 1'b1, n);
      chk(INT_RESET, 1'b1);
      // Watchdog request lasts one cycle; the others stand until released
      repeat ((s == 3) ? 1 : 3) @(posedge CLK);
      want <= 4'h0;
      WDT_EXPIRE <= 1'b0;
      #1 chk(PORT_RESET, s != 3);
      wait_sig(0, 1'b0, n);
      wait_sig(1, 1'b0, n);
      d = (s == 1) ? 6500 : 400;
      chk(n >= d && n <= d + 3, 1'b1);
      rd(`RSG_ADDR_STATUS, rv);
      chk(rv, 8'(1 << s));
    end
    wr(`RSG_ADDR_STATUS, 8'h00);
    rd(`RSG_ADDR_STATUS, rv);
    chk(rv, 8'h00);
    BROWNOUT_ENABLE_FUSE <= 1'b0;
    want <= 4'h4;
    WDT_EXPIRE <= 1'b1;
    repeat (6) @(posedge CLK);
    #1 chk(PORT_RESET, 1'b0);
    want <= 4'h0;
    WDT_EXPIRE <= 1'b0;
    // Master reset in mid-run brings the flags back to their power-up value
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    wait_sig(1, 1'b0, n);
    rd(`RSG_ADDR_STATUS, rv);
    chk(rv, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
